// >>> common/dlmod_pkg.sv
// Package of opcode patterns, operation codes and counts for the decoder.
package dlmod_pkg;

    localparam int WORD_W = 16;

    // Opcode patterns with wildcards, matched in the order of the classify casez.
    localparam logic [15:0] PAT_ZERO_ACC = 16'b1011_1001_0000_0000;
    localparam logic [15:0] PAT_ACC_SHORT = 16'b1011_1001_????_????;
    localparam logic [15:0] PAT_ZLOW_HIGH = 16'b0110_1010_????_????;
    localparam logic [15:0] PAT_ACC_NOSX = 16'b0110_1001_????_????;
    localparam logic [15:0] PAT_ACC_TSHIFT = 16'b0110_1011_????_????;
    localparam logic [15:0] PAT_AUX_MEM = 16'b0000_0???_????_????;
    localparam logic [15:0] PAT_AUX_LONG = 16'b1011_1111_0000_1???;
    localparam logic [15:0] PAT_AUX_SHORT = 16'b1011_0???_????_????;
    localparam logic [15:0] PAT_PAGE_MEM = 16'b0000_1101_????_????;
    localparam logic [15:0] PAT_PAGE_IMM = 16'b1011_110?_????_????;
    localparam logic [15:0] PAT_HIGH_PROD = 16'b0111_0101_????_????;
    localparam logic [15:0] PAT_STAT_ZERO = 16'b0000_1110_????_????;
    localparam logic [15:0] PAT_STAT_ONE = 16'b0000_1111_????_????;
    localparam logic [15:0] PAT_T_LOAD = 16'b0111_0011_????_????;
    localparam logic [15:0] PAT_T_ADD = 16'b0111_0000_????_????;
    localparam logic [15:0] PAT_T_MOVE = 16'b0111_0010_????_????;
    localparam logic [15:0] PAT_T_PROD = 16'b0111_0001_????_????;
    localparam logic [15:0] PAT_T_SUB = 16'b0111_0100_????_????;
    localparam logic [15:0] PAT_MUL_ACC = 16'b1010_0010_????_????;
    localparam logic [15:0] PAT_MUL_ACC_MV = 16'b1010_0011_????_????;
    localparam logic [15:0] PAT_AUX_PTR = 16'b1000_1011_1000_1???;
    localparam logic [15:0] PAT_NO_OP = 16'b1000_1011_0000_0000;
    localparam logic [15:0] PAT_MOD_AUX = 16'b1000_1011_????_????;
    localparam logic [15:0] PAT_MUL_T = 16'b0101_0100_????_????;
    localparam logic [15:0] PAT_MUL_IMM = 16'b110?_????_????_????;
    localparam logic [15:0] PAT_MUL_ADD = 16'b0101_0000_????_????;
    localparam logic [15:0] PAT_MUL_SUB = 16'b0101_0001_????_????;
    localparam logic [15:0] PAT_MUL_UNS = 16'b0101_0101_????_????;
    localparam logic [15:0] PAT_PROD_ACC = 16'b1011_1110_0000_0011;
    localparam logic [15:0] PAT_INV_SIGN = 16'b1011_1110_0000_0010;
    localparam logic [15:0] PAT_EXP_SHIFT = 16'b1010_0000_????_????;
    localparam logic [15:0] PAT_NONMASK = 16'b1011_1110_0101_0010;
    localparam logic [15:0] PAT_OR_MEM = 16'b0110_1101_????_????;
    localparam logic [15:0] PAT_OR_SHIFT = 16'b1011_1111_1100_????;
    localparam logic [15:0] PAT_OR_16 = 16'b1011_1110_1000_0010;

    // Field positions inside the first word.
    localparam int IND_BIT = 7;
    localparam int AUX_HI_LSB = 8;
    localparam int AUX_W = 3;
    localparam int SHIFT_W = 5;
    localparam int PAGE_W = 9;
    localparam int MUL_K_W = 13;
    localparam int SHORT_W = 8;
    localparam int OFFS_W = 7;

    localparam logic [4:0] SHIFT_16 = 5'h10;
    localparam logic [1:0] WORDS_1 = 2'h1;
    localparam logic [1:0] WORDS_2 = 2'h2;
    localparam logic [2:0] CYC_1 = 3'h1;
    localparam logic [2:0] CYC_2 = 3'h2;
    localparam logic [2:0] CYC_3 = 3'h3;
    localparam logic [2:0] CYC_4 = 3'h4;

    typedef enum logic [5:0] {
        OP_NONE, OP_ZERO_ACC, OP_ACC_SHORT, OP_ZLOW_HIGH, OP_ACC_NOSX,
        OP_ACC_TSHIFT, OP_AUX_MEM, OP_AUX_SHORT, OP_AUX_LONG, OP_PAGE_MEM,
        OP_PAGE_IMM, OP_HIGH_PROD, OP_STAT_ZERO, OP_STAT_ONE, OP_T_LOAD,
        OP_T_ADD, OP_T_MOVE, OP_T_PROD, OP_T_SUB, OP_MUL_ACC,
        OP_MUL_ACC_MV, OP_AUX_PTR, OP_NO_OP, OP_MOD_AUX, OP_MUL_T,
        OP_MUL_IMM, OP_MUL_ADD, OP_MUL_SUB, OP_MUL_UNS, OP_PROD_ACC,
        OP_INV_SIGN, OP_EXP_SHIFT, OP_NONMASK, OP_OR_MEM, OP_OR_SHIFT,
        OP_OR_16
    } dlmod_op_t;

    typedef enum logic [1:0] {
        ST_FIRST = 2'b01,
        ST_SECOND = 2'b10
    } dlmod_state_t;

endpackage

// >>> rtl/dlmod_decoder.sv
// Decoder for the load, multiply, normalize and OR instruction group.
// Notes on behaviour
// - 1011 1001 loads acc from 8-bit short constant; zero constant clears.
// - 0110 1010 clears low half, loads word into high half; 1/1.
// - 0110 1001 clears acc, loads low half without sign extension; 1/1.
// - 0110 1011 loads acc shifted by T operand count; 1/1.
// - Aux load: memory 1/2, short immediate 1/2, long immediate 2/2.
// - Page pointer load from memory or packed immediate; each 1/2.
// - Status word zero 0000 1110, status word one 0000 1111; 1/2.
// - T loads under high nibble 0111, five variants, each 1/1.
// - Multiply-accumulate 1010 0010, with move 1010 0011; each 2/3.
// - 1000 1011 modifies aux only; pointer load form; zero byte is nop.
// - Multiply by T 0101 0100; immediate 110C with 13-bit constant; 1/1.
// - Multiply with add, with subtract, and unsigned; one cycle each.
// - Product to acc and negate acc; each one word, one cycle.
// - Normalize 1010 0000 in one cycle; nonmaskable interrupt 1/4.
// - OR memory 1/1; OR shifted constant and shift-16 constant 2/2.
`timescale 1ns/1ps
module dlmod_decoder #(
    parameter int WORD_W = dlmod_pkg::WORD_W
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // Fetch side
    input wire logic word_valid_i,
    input wire logic [15:0] word_i,
    // Datapath control side
    output logic dec_valid_o,
    output dlmod_pkg::dlmod_op_t op_o,
    output logic [1:0] words_o,
    output logic [2:0] cycles_o,
    output logic mem_operand_o,
    output logic indirect_o,
    output logic [6:0] addr_field_o,
    output logic [2:0] aux_sel_o,
    output logic [4:0] shift_o,
    output logic [15:0] const_o
);

    if (WORD_W != 16) begin : g_width_check
        $error("dlmod_decoder supports only a 16-bit instruction word");
    end

    // Patterns overlap, so matching order is significant.
    function automatic dlmod_pkg::dlmod_op_t classify(input logic [15:0] w);
        casez (w)
            dlmod_pkg::PAT_ZERO_ACC: classify = dlmod_pkg::OP_ZERO_ACC;
            dlmod_pkg::PAT_ACC_SHORT: classify = dlmod_pkg::OP_ACC_SHORT;
            dlmod_pkg::PAT_ZLOW_HIGH: classify = dlmod_pkg::OP_ZLOW_HIGH;
            dlmod_pkg::PAT_ACC_NOSX: classify = dlmod_pkg::OP_ACC_NOSX;
            dlmod_pkg::PAT_ACC_TSHIFT: classify = dlmod_pkg::OP_ACC_TSHIFT;
            dlmod_pkg::PAT_PAGE_MEM: classify = dlmod_pkg::OP_PAGE_MEM;
            dlmod_pkg::PAT_STAT_ZERO: classify = dlmod_pkg::OP_STAT_ZERO;
            dlmod_pkg::PAT_STAT_ONE: classify = dlmod_pkg::OP_STAT_ONE;
            dlmod_pkg::PAT_AUX_MEM: classify = dlmod_pkg::OP_AUX_MEM;
            dlmod_pkg::PAT_AUX_LONG: classify = dlmod_pkg::OP_AUX_LONG;
            dlmod_pkg::PAT_OR_SHIFT: classify = dlmod_pkg::OP_OR_SHIFT;
            dlmod_pkg::PAT_OR_16: classify = dlmod_pkg::OP_OR_16;
            dlmod_pkg::PAT_PROD_ACC: classify = dlmod_pkg::OP_PROD_ACC;
            dlmod_pkg::PAT_INV_SIGN: classify = dlmod_pkg::OP_INV_SIGN;
            dlmod_pkg::PAT_NONMASK: classify = dlmod_pkg::OP_NONMASK;
            dlmod_pkg::PAT_PAGE_IMM: classify = dlmod_pkg::OP_PAGE_IMM;
            dlmod_pkg::PAT_AUX_SHORT: classify = dlmod_pkg::OP_AUX_SHORT;
            dlmod_pkg::PAT_HIGH_PROD: classify = dlmod_pkg::OP_HIGH_PROD;
            dlmod_pkg::PAT_T_LOAD: classify = dlmod_pkg::OP_T_LOAD;
            dlmod_pkg::PAT_T_ADD: classify = dlmod_pkg::OP_T_ADD;
            dlmod_pkg::PAT_T_MOVE: classify = dlmod_pkg::OP_T_MOVE;
            dlmod_pkg::PAT_T_PROD: classify = dlmod_pkg::OP_T_PROD;
            dlmod_pkg::PAT_T_SUB: classify = dlmod_pkg::OP_T_SUB;
            dlmod_pkg::PAT_MUL_ACC: classify = dlmod_pkg::OP_MUL_ACC;
            dlmod_pkg::PAT_MUL_ACC_MV: classify = dlmod_pkg::OP_MUL_ACC_MV;
            dlmod_pkg::PAT_AUX_PTR: classify = dlmod_pkg::OP_AUX_PTR;
            dlmod_pkg::PAT_NO_OP: classify = dlmod_pkg::OP_NO_OP;
            dlmod_pkg::PAT_MOD_AUX: classify = dlmod_pkg::OP_MOD_AUX;
            dlmod_pkg::PAT_MUL_T: classify = dlmod_pkg::OP_MUL_T;
            dlmod_pkg::PAT_MUL_IMM: classify = dlmod_pkg::OP_MUL_IMM;
            dlmod_pkg::PAT_MUL_ADD: classify = dlmod_pkg::OP_MUL_ADD;
            dlmod_pkg::PAT_MUL_SUB: classify = dlmod_pkg::OP_MUL_SUB;
            dlmod_pkg::PAT_MUL_UNS: classify = dlmod_pkg::OP_MUL_UNS;
            dlmod_pkg::PAT_EXP_SHIFT: classify = dlmod_pkg::OP_EXP_SHIFT;
            dlmod_pkg::PAT_OR_MEM: classify = dlmod_pkg::OP_OR_MEM;
            default: classify = dlmod_pkg::OP_NONE;
        endcase
    endfunction

    function automatic logic two_words(input dlmod_pkg::dlmod_op_t op);
        two_words = op inside {dlmod_pkg::OP_AUX_LONG,
            dlmod_pkg::OP_MUL_ACC, dlmod_pkg::OP_MUL_ACC_MV,
            dlmod_pkg::OP_OR_SHIFT, dlmod_pkg::OP_OR_16};
    endfunction

    function automatic logic [2:0] cycle_count(input dlmod_pkg::dlmod_op_t op);
        case (op)
            dlmod_pkg::OP_AUX_MEM, dlmod_pkg::OP_AUX_SHORT,
            dlmod_pkg::OP_AUX_LONG: cycle_count = dlmod_pkg::CYC_2;
            dlmod_pkg::OP_PAGE_MEM,
            dlmod_pkg::OP_PAGE_IMM: cycle_count = dlmod_pkg::CYC_2;
            dlmod_pkg::OP_STAT_ZERO,
            dlmod_pkg::OP_STAT_ONE: cycle_count = dlmod_pkg::CYC_2;
            dlmod_pkg::OP_MUL_ACC,
            dlmod_pkg::OP_MUL_ACC_MV: cycle_count = dlmod_pkg::CYC_3;
            dlmod_pkg::OP_OR_SHIFT,
            dlmod_pkg::OP_OR_16: cycle_count = dlmod_pkg::CYC_2;
            dlmod_pkg::OP_NONMASK: cycle_count = dlmod_pkg::CYC_4;
            default: cycle_count = dlmod_pkg::CYC_1;
        endcase
    endfunction

    // Opcodes that carry an operand address in the low byte.
    function automatic logic has_mem(input dlmod_pkg::dlmod_op_t op);
        has_mem = op inside {dlmod_pkg::OP_ZLOW_HIGH, dlmod_pkg::OP_ACC_NOSX,
            dlmod_pkg::OP_ACC_TSHIFT, dlmod_pkg::OP_AUX_MEM,
            dlmod_pkg::OP_PAGE_MEM, dlmod_pkg::OP_HIGH_PROD,
            dlmod_pkg::OP_STAT_ZERO, dlmod_pkg::OP_STAT_ONE,
            dlmod_pkg::OP_T_LOAD, dlmod_pkg::OP_T_ADD, dlmod_pkg::OP_T_MOVE,
            dlmod_pkg::OP_T_PROD, dlmod_pkg::OP_T_SUB, dlmod_pkg::OP_MUL_ACC,
            dlmod_pkg::OP_MUL_ACC_MV, dlmod_pkg::OP_MOD_AUX,
            dlmod_pkg::OP_MUL_T, dlmod_pkg::OP_MUL_ADD,
            dlmod_pkg::OP_MUL_SUB, dlmod_pkg::OP_MUL_UNS,
            dlmod_pkg::OP_EXP_SHIFT, dlmod_pkg::OP_OR_MEM};
    endfunction

    dlmod_pkg::dlmod_state_t state_q, state_d;
    dlmod_pkg::dlmod_op_t op_q, op_d, first_op;
    logic [15:0] first_q, first_d, src;
    logic dec_valid_q, dec_valid_d;
    logic [1:0] words_q, words_d;
    logic [2:0] cycles_q, cycles_d;
    logic mem_q, mem_d, ind_q, ind_d;
    logic [6:0] addr_q, addr_d;
    logic [2:0] aux_q, aux_d;
    logic [4:0] shift_q, shift_d;
    logic [15:0] const_q, const_d;

    assign first_op = classify(word_i);

    always_comb begin
        state_d = state_q;
        first_d = first_q;
        op_d = op_q;
        dec_valid_d = 1'b0;
        words_d = words_q;
        cycles_d = cycles_q;
        mem_d = mem_q;
        ind_d = ind_q;
        addr_d = addr_q;
        aux_d = aux_q;
        shift_d = shift_q;
        const_d = const_q;
        src = word_i;
        unique case (state_q)
            dlmod_pkg::ST_FIRST: begin
                if (word_valid_i) begin
                    op_d = first_op;
                    first_d = word_i;
                    if (two_words(first_op)) begin
                        state_d = dlmod_pkg::ST_SECOND;
                    end else begin
                        dec_valid_d = 1'b1;
                    end
                end
            end
            dlmod_pkg::ST_SECOND: begin
                src = first_q;
                if (word_valid_i) begin
                    // The trailing word is the constant operand.
                    dec_valid_d = 1'b1;
                    state_d = dlmod_pkg::ST_FIRST;
                end
            end
            default: state_d = dlmod_pkg::ST_FIRST;
        endcase
        if (dec_valid_d) begin
            words_d = two_words(op_d) ? dlmod_pkg::WORDS_2
                                      : dlmod_pkg::WORDS_1;
            cycles_d = cycle_count(op_d);
            mem_d = has_mem(op_d);
            ind_d = has_mem(op_d) & src[dlmod_pkg::IND_BIT];
            addr_d = src[dlmod_pkg::OFFS_W-1:0];
            aux_d = '0;
            shift_d = '0;
            const_d = '0;
            case (op_d)
                dlmod_pkg::OP_ACC_SHORT, dlmod_pkg::OP_ZERO_ACC:
                    const_d = 16'(src[dlmod_pkg::SHORT_W-1:0]);
                dlmod_pkg::OP_AUX_MEM: aux_d =
                    src[dlmod_pkg::AUX_HI_LSB +: dlmod_pkg::AUX_W];
                dlmod_pkg::OP_AUX_SHORT: begin
                    aux_d = src[dlmod_pkg::AUX_HI_LSB +: dlmod_pkg::AUX_W];
                    const_d = 16'(src[dlmod_pkg::SHORT_W-1:0]);
                end
                dlmod_pkg::OP_AUX_LONG: begin
                    aux_d = src[dlmod_pkg::AUX_W-1:0];
                    const_d = word_i;
                end
                dlmod_pkg::OP_PAGE_IMM:
                    const_d = 16'(src[dlmod_pkg::PAGE_W-1:0]);
                dlmod_pkg::OP_MUL_ACC, dlmod_pkg::OP_MUL_ACC_MV:
                    const_d = word_i;
                dlmod_pkg::OP_AUX_PTR:
                    aux_d = src[dlmod_pkg::AUX_W-1:0];
                dlmod_pkg::OP_MUL_IMM:
                    const_d = 16'(src[dlmod_pkg::MUL_K_W-1:0]);
                dlmod_pkg::OP_OR_SHIFT: begin
                    shift_d = 5'(src[3:0]);
                    const_d = word_i;
                end
                dlmod_pkg::OP_OR_16: begin
                    shift_d = dlmod_pkg::SHIFT_16;
                    const_d = word_i;
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_q <= dlmod_pkg::ST_FIRST;
            first_q <= 16'h0000;
            op_q <= dlmod_pkg::OP_NONE;
            dec_valid_q <= 1'b0;
            words_q <= 2'h0;
            cycles_q <= 3'h0;
            mem_q <= 1'b0;
            ind_q <= 1'b0;
            addr_q <= 7'h00;
            aux_q <= 3'h0;
            shift_q <= 5'h00;
            const_q <= 16'h0000;
        end else begin
            state_q <= state_d;
            first_q <= first_d;
            op_q <= op_d;
            dec_valid_q <= dec_valid_d;
            words_q <= words_d;
            cycles_q <= cycles_d;
            mem_q <= mem_d;
            ind_q <= ind_d;
            addr_q <= addr_d;
            aux_q <= aux_d;
            shift_q <= shift_d;
            const_q <= const_d;
        end
    end

    assign dec_valid_o = dec_valid_q;
    assign op_o = op_q;
    assign words_o = words_q;
    assign cycles_o = cycles_q;
    assign mem_operand_o = mem_q;
    assign indirect_o = ind_q;
    assign addr_field_o = addr_q;
    assign aux_sel_o = aux_q;
    assign shift_o = shift_q;
    assign const_o = const_q;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);

    sequence s_lead;
        state_q == dlmod_pkg::ST_FIRST && word_valid_i && two_words(first_op);
    endsequence
    sequence s_single;
        state_q == dlmod_pkg::ST_FIRST && word_valid_i && !two_words(first_op);
    endsequence

    function automatic logic done(input dlmod_pkg::dlmod_op_t op);
        done = dec_valid_o && op_o == op;
    endfunction

    a_short_load: assert property (s_single ##0 word_i[15:8] == 8'hB9
        |=> dec_valid_o && const_o == 16'($past(word_i[7:0])))
        else $error("short constant load decoded wrongly");
    a_acc_loads: assert property (s_single ##0 word_i[15:10] == 6'h1A
        |=> dec_valid_o && cycles_o == 3'h1 && words_o == 2'h1)
        else $error("accumulator load timing wrong");
    a_tshift_op: assert property (s_single ##0 word_i[15:8] == 8'h6B
        |=> op_o == dlmod_pkg::OP_ACC_TSHIFT)
        else $error("T-shift load not recognised");
    a_long_pair: assert property (s_lead ##1 word_valid_i
        |=> dec_valid_o && words_o == 2'h2 && const_o == $past(word_i))
        else $error("two-word instruction not paired");
    a_lead_quiet: assert property (s_lead |=> !dec_valid_o)
        else $error("output given before the constant word");
    a_aux_cycles: assert property (done(dlmod_pkg::OP_AUX_SHORT)
        || done(dlmod_pkg::OP_PAGE_IMM) || done(dlmod_pkg::OP_STAT_ONE)
        |-> cycles_o == 3'h2)
        else $error("two-cycle load reported wrong cycles");
    a_mac_cycles: assert property (done(dlmod_pkg::OP_MUL_ACC_MV)
        |-> cycles_o == 3'h3 && words_o == 2'h2)
        else $error("multiply-accumulate count wrong");
    a_nmi_cycles: assert property (s_single ##0 word_i == 16'hBE52
        |=> dec_valid_o && cycles_o == 3'h4)
        else $error("nonmaskable interrupt count wrong");
    a_mode_bit: assert property (s_single ##0 word_i[15:8] == 8'h73
        |=> indirect_o == $past(word_i[7]) && mem_operand_o)
        else $error("addressing mode bit not passed on");
    a_or_shift16: assert property (done(dlmod_pkg::OP_OR_16)
        |-> shift_o == 5'h10 && cycles_o == 3'h2)
        else $error("OR with shift of 16 decoded wrongly");

endmodule // dlmod_decoder

// >>> tb/dlmod_fetch_model.sv
// Behavioural instruction fetch unit that feeds words to the decoder.
`timescale 1ns/1ps
module dlmod_fetch_model (
    // Clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // Bench control
    input wire logic gap_en_i,
    // Word stream towards the decoder
    output logic word_valid_o,
    output logic [15:0] word_o
);
    logic [15:0] fifo_q[$];
    integer seed = 32'h154D5D84;
    logic stall;

    task automatic put(input logic [15:0] w);
        fifo_q.push_back(w);
    endtask

    // An idle bus inverts the word it showed the cycle before, so the decoder
    // cannot get away with using a stale word that merely looks held.
    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            word_valid_o <= 1'b0;
            word_o <= 16'h0000;
        end else begin
            stall = gap_en_i && (($random(seed) & 3) == 0);
            if (fifo_q.size() > 0 && !stall) begin
                word_valid_o <= 1'b1;
                word_o <= fifo_q.pop_front();
            end else begin
                word_valid_o <= 1'b0;
                word_o <= ~word_o;
            end
        end
    end
endmodule // dlmod_fetch_model

// >>> tb/testbench.sv
// Self-checking bench for the load, multiply and OR instruction decoder.
`timescale 1ns/1ps
module testbench;
    typedef struct packed {
        dlmod_pkg::dlmod_op_t op;
        logic [1:0] words;
        logic [2:0] cyc;
        logic mem;
        logic ind;
        logic known;
        logic [6:0] addr;
        logic [2:0] aux;
        logic [4:0] sh;
        logic [15:0] k;
    } dlmod_exp_t;

    logic clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic gap_en = 1'b0;
    logic word_valid_i;
    logic [15:0] word_i;
    logic dec_valid_o, mem_operand_o, indirect_o;
    dlmod_pkg::dlmod_op_t op_o;
    logic [1:0] words_o;
    logic [2:0] cycles_o, aux_sel_o;
    logic [6:0] addr_field_o;
    logic [4:0] shift_o;
    logic [15:0] const_o;
    integer seed = 32'h154D5D84;
    int mismatches = 0;
    int comparisons = 0;
    dlmod_exp_t exp_e, pend_e, e;
    logic exp_v = 1'b0;
    logic pend = 1'b0;
    logic [15:0] corner[$] = '{16'hB900, 16'hB9FF, 16'h6A85, 16'h6912,
        16'h6BFF, 16'h0380, 16'h077F, 16'hB37F, 16'hBF0D, 16'hFFFF,
        16'hBF08, 16'h0001, 16'h0D01, 16'hBD23, 16'hBC00, 16'h7581,
        16'h0E7F, 16'h0F80, 16'h7300, 16'h7001, 16'h7202, 16'h7103,
        16'h7404, 16'hA210, 16'h1234, 16'hA3FF, 16'h0000, 16'h8B8E,
        16'h8B00, 16'h8BA5, 16'h54C0, 16'hDFFF, 16'hC001, 16'h5000,
        16'h5101, 16'h55FF, 16'hBE03, 16'hBE02, 16'hA0A0, 16'hBE52,
        16'h6D81, 16'hBFC7, 16'h8001, 16'hBE82, 16'h7FFF, 16'h0C10};

    initial forever #5 clk_i = ~clk_i;

    dlmod_fetch_model fetch_u (.clk_i(clk_i), .nrst_i(nrst_i),
        .gap_en_i(gap_en), .word_valid_o(word_valid_i), .word_o(word_i));

    dlmod_decoder dut_u (.clk_i(clk_i), .nrst_i(nrst_i),
        .word_valid_i(word_valid_i), .word_i(word_i),
        .dec_valid_o(dec_valid_o), .op_o(op_o), .words_o(words_o),
        .cycles_o(cycles_o), .mem_operand_o(mem_operand_o),
        .indirect_o(indirect_o), .addr_field_o(addr_field_o),
        .aux_sel_o(aux_sel_o), .shift_o(shift_o), .const_o(const_o));

    // A mode of 2 marks forms whose address-byte reading is left open.
    function automatic dlmod_exp_t m(input dlmod_pkg::dlmod_op_t op,
            input int wd, input int cy, input int mode, input logic [15:0] w);
        dlmod_exp_t r;
        r = '0;
        r.op = op;
        r.words = wd[1:0];
        r.cyc = cy[2:0];
        r.mem = (mode == 1);
        r.ind = (mode == 1) & w[7];
        r.known = (mode != 2);
        r.addr = w[6:0];
        return r;
    endfunction

    function automatic dlmod_exp_t dec(input logic [15:0] w);
        dlmod_exp_t r;
        r = m(dlmod_pkg::OP_NONE, 1, 1, 0, w);
        casez (w)
        16'hB900: r = m(dlmod_pkg::OP_ZERO_ACC, 1, 1, 0, w);
        16'hB9??: begin
            r = m(dlmod_pkg::OP_ACC_SHORT, 1, 1, 0, w);
            r.k = {8'h00, w[7:0]};
        end
        16'h6A??: r = m(dlmod_pkg::OP_ZLOW_HIGH, 1, 1, 1, w);
        16'h69??: r = m(dlmod_pkg::OP_ACC_NOSX, 1, 1, 1, w);
        16'h6B??: r = m(dlmod_pkg::OP_ACC_TSHIFT, 1, 1, 1, w);
        16'b0000_0???_????_????: begin
            r = m(dlmod_pkg::OP_AUX_MEM, 1, 2, 1, w);
            r.aux = w[10:8];
        end
        16'b1011_0???_????_????: begin
            r = m(dlmod_pkg::OP_AUX_SHORT, 1, 2, 0, w);
            r.aux = w[10:8];
            r.k = {8'h00, w[7:0]};
        end
        16'b1011_1111_0000_1???: begin
            r = m(dlmod_pkg::OP_AUX_LONG, 2, 2, 0, w);
            r.aux = w[2:0];
        end
        16'h0D??: r = m(dlmod_pkg::OP_PAGE_MEM, 1, 2, 1, w);
        16'b1011_110?_????_????: begin
            r = m(dlmod_pkg::OP_PAGE_IMM, 1, 2, 0, w);
            r.k = {7'h00, w[8:0]};
        end
        16'h75??: r = m(dlmod_pkg::OP_HIGH_PROD, 1, 1, 1, w);
        16'h0E??: r = m(dlmod_pkg::OP_STAT_ZERO, 1, 2, 1, w);
        16'h0F??: r = m(dlmod_pkg::OP_STAT_ONE, 1, 2, 1, w);
        16'h73??: r = m(dlmod_pkg::OP_T_LOAD, 1, 1, 1, w);
        16'h70??: r = m(dlmod_pkg::OP_T_ADD, 1, 1, 1, w);
        16'h72??: r = m(dlmod_pkg::OP_T_MOVE, 1, 1, 1, w);
        16'h71??: r = m(dlmod_pkg::OP_T_PROD, 1, 1, 1, w);
        16'h74??: r = m(dlmod_pkg::OP_T_SUB, 1, 1, 1, w);
        16'hA2??: r = m(dlmod_pkg::OP_MUL_ACC, 2, 3, 1, w);
        16'hA3??: r = m(dlmod_pkg::OP_MUL_ACC_MV, 2, 3, 1, w);
        16'b1000_1011_1000_1???: begin
            r = m(dlmod_pkg::OP_AUX_PTR, 1, 1, 2, w);
            r.aux = w[2:0];
        end
        16'h8B00: r = m(dlmod_pkg::OP_NO_OP, 1, 1, 2, w);
        16'h8B??: r = m(dlmod_pkg::OP_MOD_AUX, 1, 1, 1, w);
        16'h54??: r = m(dlmod_pkg::OP_MUL_T, 1, 1, 1, w);
        16'b110?_????_????_????: begin
            r = m(dlmod_pkg::OP_MUL_IMM, 1, 1, 0, w);
            r.k = {3'h0, w[12:0]};
        end
        16'h50??: r = m(dlmod_pkg::OP_MUL_ADD, 1, 1, 1, w);
        16'h51??: r = m(dlmod_pkg::OP_MUL_SUB, 1, 1, 1, w);
        16'h55??: r = m(dlmod_pkg::OP_MUL_UNS, 1, 1, 1, w);
        16'hBE03: r = m(dlmod_pkg::OP_PROD_ACC, 1, 1, 0, w);
        16'hBE02: r = m(dlmod_pkg::OP_INV_SIGN, 1, 1, 0, w);
        16'hA0??: r = m(dlmod_pkg::OP_EXP_SHIFT, 1, 1, 1, w);
        16'hBE52: r = m(dlmod_pkg::OP_NONMASK, 1, 4, 0, w);
        16'h6D??: r = m(dlmod_pkg::OP_OR_MEM, 1, 1, 1, w);
        16'hBFC?: begin
            r = m(dlmod_pkg::OP_OR_SHIFT, 2, 2, 0, w);
            r.sh = {1'b0, w[3:0]};
        end
        16'hBE82: begin
            r = m(dlmod_pkg::OP_OR_16, 2, 2, 0, w);
            r.sh = 5'h10;
        end
        default: ;
        endcase
        return r;
    endfunction

    task automatic chk(input logic [15:0] got, input logic [15:0] want);
        comparisons++;
        if (got !== want) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got,
                want);
        end
    endtask

    always @(negedge nrst_i) begin
        pend = 1'b0;
        exp_v = 1'b0;
    end

    // Outputs are sampled before the edge lands, so the pulse seen here
    // belongs to the word that was taken one edge earlier.
    always @(posedge clk_i) begin
        if (nrst_i === 1'b1) begin
            chk(dec_valid_o, exp_v);
            if (dec_valid_o === 1'b1 && exp_v) begin
                chk(op_o, exp_e.op);
                chk(words_o, exp_e.words);
                chk(cycles_o, exp_e.cyc);
                chk(aux_sel_o, exp_e.aux);
                chk(shift_o, exp_e.sh);
                chk(const_o, exp_e.k);
                chk(addr_field_o, exp_e.addr);
                if (exp_e.known) begin
                    chk(mem_operand_o, exp_e.mem);
                    chk(indirect_o, exp_e.ind);
                end
            end
            exp_v = 1'b0;
            if (word_valid_i === 1'b1) begin
                if (pend) begin
                    exp_e = pend_e;
                    exp_e.k = word_i;
                    pend = 1'b0;
                    exp_v = 1'b1;
                end else begin
                    e = dec(word_i);
                    pend = (e.words == 2'h2);
                    pend_e = e;
                    exp_e = e;
                    exp_v = !pend;
                end
            end
        end
    end

    task automatic drain();
        int n;
        n = 0;
        while (fetch_u.fifo_q.size() != 0 && n < 20000) begin
            @(posedge clk_i);
            n++;
        end
        repeat (3) @(posedge clk_i);
    endtask

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    initial begin
        #500000;
        mismatches++;
        test_done();
    end

    initial begin
        repeat (2) @(posedge clk_i);
        #1;
        chk(dec_valid_o, 1'b0);
        chk(op_o, dlmod_pkg::OP_NONE);
        chk(const_o, 16'h0000);
        @(posedge clk_i);
        nrst_i <= 1'b1;
        foreach (corner[i]) fetch_u.put(corner[i]);
        drain();
        gap_en <= 1'b1;
        repeat (1500) fetch_u.put(16'($random(seed)));
        fetch_u.put(16'h8B00);
        fetch_u.put(16'h8B00);
        drain();
        gap_en <= 1'b0;
        fetch_u.put(16'hA210);
        drain();
        nrst_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        #1;
        chk(dec_valid_o, 1'b0);
        chk(op_o, dlmod_pkg::OP_NONE);
        @(posedge clk_i);
        nrst_i <= 1'b1;
        fetch_u.put(16'hB905);
        drain();
        test_done();
    end
endmodule // testbench
